/* logic/enhanced_serial_port.sv */
`timescale 1ns/1ps
module enhanced_serial_port #(
  parameter int RELOAD_WIDTH = 15 // Width of the baud timer reload.
) (
  input wire logic clk_sys, // System clock, 10 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire serial_port_pkg::ctrl_t serialControl, // Mode, speed, enable, ninth bit.
  input wire logic baudDoubleBit, // Doubles the mode 2 rate.
  input wire logic [RELOAD_WIDTH-1:0] baudReload, // Baud timer reload value.
  input wire logic [7:0] txWriteData, // Byte written to the serial buffer.
  input wire logic txWriteStb, // One-cycle serial buffer write.
  input wire logic txFlagClear, // One-cycle clear of transmit flag.
  input wire logic rxFlagClear, // One-cycle clear of receive flag.
  input wire logic rxdIn, // RxD pin level.
  output logic rxdOut, // RxD drive value, mode 0 send.
  output logic rxdOe, // RxD output enable, high while driving.
  output logic txdOut, // TxD pin: shift clock or serial data.
  output logic [7:0] serialBuffer, // Last accepted received byte.
  output serial_port_pkg::status_t serialStatus // Flags and received ninth bit.
);

  // ************************************************************
  // Mode decode and shared timing
  // ************************************************************

  serial_port_pkg::mode_t mode;
  logic isShift;
  logic isNine;
  logic rxSync;
  logic sampleTick;
  logic shiftPhase;

  assign mode = serial_port_pkg::mode_of(serialControl);
  assign isShift = (mode == serial_port_pkg::MODE_SHIFT);
  assign isNine = (mode == serial_port_pkg::MODE_ASYNC9_FIXED)
               || (mode == serial_port_pkg::MODE_ASYNC9_TIMER);

  pin_sync #(
    .WIDTH(1)
  ) u_rxd_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pinIn(rxdIn),
    .pinSync(rxSync)
  );

  baud_gen #(
    .RELOAD_WIDTH(RELOAD_WIDTH)
  ) u_baud (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .mode(mode),
    .speedBit(serialControl.multiprocSpeedBit),
    .baudDouble(baudDoubleBit),
    .reload(baudReload),
    .sampleTick(sampleTick),
    .shiftPhase(shiftPhase)
  );

  // ************************************************************
  // Flags and receive buffer
  // ************************************************************

  logic riFlag_ff;
  logic tiFlag_ff;
  logic ninth_ff;
  logic [7:0] buffer_ff;
  logic m0TxDone_ff;
  logic m0RxDone_ff;
  logic txStopPulse_ff;
  logic rxAccept_ff;
  logic [7:0] rxByte_ff;
  logic rxNinth_ff;
  logic [7:0] m0Shift_ff;

  // A set in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tiFlag_ff <= 1'b0;
    end else if (m0TxDone_ff || txStopPulse_ff) begin
      tiFlag_ff <= 1'b1;
    end else if (txFlagClear) begin
      tiFlag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      riFlag_ff <= 1'b0;
    end else if (m0RxDone_ff || rxAccept_ff) begin
      riFlag_ff <= 1'b1;
    end else if (rxFlagClear) begin
      riFlag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      buffer_ff <= serial_port_pkg::BYTE_RESET;
      ninth_ff <= 1'b0;
    end else if (m0RxDone_ff) begin
      // The shift register fills leftwards, so the first bit ends up at the top.
      buffer_ff <= serial_port_pkg::reverse8(m0Shift_ff);
    end else if (rxAccept_ff) begin
      buffer_ff <= rxByte_ff;
      ninth_ff <= rxNinth_ff;
    end
  end

  assign serialBuffer = buffer_ff;
  assign serialStatus = '{receiveDoneFlag: riFlag_ff,
                          transmitDoneFlag: tiFlag_ff,
                          receivedNinthBit: ninth_ff};

  // ************************************************************
  // Mode 0 synchronous shift engine
  // ************************************************************

  serial_port_pkg::m0_state_t m0State_ff;
  logic [2:0] m0Cnt_ff;
  logic m0Clk_ff;
  logic m0Data_ff;
  logic m0RxStart;

  // Receive waits for the flag from the last byte to land before it rearms.
  assign m0RxStart = serialControl.receiveEnable && !riFlag_ff && !m0RxDone_ff;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      m0State_ff <= serial_port_pkg::M0_IDLE;
      m0Cnt_ff <= 3'h0;
      m0Clk_ff <= 1'b1;
      m0Data_ff <= 1'b1;
      m0Shift_ff <= serial_port_pkg::BYTE_RESET;
      m0TxDone_ff <= 1'b0;
      m0RxDone_ff <= 1'b0;
    end else begin
      m0TxDone_ff <= 1'b0;
      m0RxDone_ff <= 1'b0;
      if (!isShift) begin
        m0State_ff <= serial_port_pkg::M0_IDLE;
        m0Clk_ff <= 1'b1;
      end else begin
        case (m0State_ff)
          serial_port_pkg::M0_IDLE: begin
            m0Clk_ff <= 1'b1;
            m0Cnt_ff <= 3'h0;
            if (txWriteStb) begin
              m0State_ff <= serial_port_pkg::M0_SEND;
              m0Shift_ff <= txWriteData;
            end else if (m0RxStart) begin
              m0State_ff <= serial_port_pkg::M0_RECV;
            end
          end
          serial_port_pkg::M0_SEND: begin
            if (shiftPhase) begin
              if (m0Clk_ff) begin
                m0Clk_ff <= 1'b0;
                m0Data_ff <= m0Shift_ff[0];
                m0Shift_ff <= {1'b0, m0Shift_ff[7:1]};
              end else begin
                m0Clk_ff <= 1'b1;
                if (m0Cnt_ff == serial_port_pkg::M0_LAST_BIT) begin
                  m0State_ff <= serial_port_pkg::M0_IDLE;
                  m0TxDone_ff <= 1'b1;
                end else begin
                  m0Cnt_ff <= m0Cnt_ff + 3'h1;
                end
              end
            end
          end
          serial_port_pkg::M0_RECV: begin
            if (shiftPhase) begin
              if (m0Clk_ff) begin
                m0Clk_ff <= 1'b0;
              end else begin
                m0Clk_ff <= 1'b1;
                m0Shift_ff <= {m0Shift_ff[6:0], rxSync};
                if (m0Cnt_ff == serial_port_pkg::M0_LAST_BIT) begin
                  m0State_ff <= serial_port_pkg::M0_IDLE;
                  m0RxDone_ff <= 1'b1;
                end else begin
                  m0Cnt_ff <= m0Cnt_ff + 3'h1;
                end
              end
            end
          end
          default: begin
            m0State_ff <= serial_port_pkg::M0_IDLE;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Asynchronous transmitter
  // ************************************************************

  serial_port_pkg::tx_state_t txState_ff;
  logic [3:0] txDiv_ff;
  logic [3:0] txLeft_ff;
  logic [9:0] txShift_ff;
  logic txLine_ff;
  logic txRoll;

  assign txRoll = sampleTick && (txDiv_ff == serial_port_pkg::DIV16_LAST);

  // Free-running divide-by-16; bit times follow it, not the buffer write.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txDiv_ff <= 4'h0;
    end else if (sampleTick) begin
      txDiv_ff <= txDiv_ff + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txState_ff <= serial_port_pkg::TX_IDLE;
      txLeft_ff <= 4'h0;
      txShift_ff <= '1;
      txLine_ff <= 1'b1;
      txStopPulse_ff <= 1'b0;
    end else begin
      txStopPulse_ff <= 1'b0;
      if (isShift) begin
        txState_ff <= serial_port_pkg::TX_IDLE;
        txLine_ff <= 1'b1;
      end else if (txWriteStb) begin
        // Mode 1 puts a stop bit in the ninth slot, so the stop follows the byte.
        txState_ff <= serial_port_pkg::TX_WAIT;
        txShift_ff <= {1'b1, isNine ? serialControl.transmitNinthBit : 1'b1, txWriteData};
        txLeft_ff <= isNine ? serial_port_pkg::TX_LEFT_9 : serial_port_pkg::TX_LEFT_8;
      end else begin
        case (txState_ff)
          serial_port_pkg::TX_IDLE: begin
            txLine_ff <= 1'b1;
          end
          serial_port_pkg::TX_WAIT: begin
            if (txRoll) begin
              txState_ff <= serial_port_pkg::TX_SHIFT;
              txLine_ff <= 1'b0;
            end
          end
          serial_port_pkg::TX_SHIFT: begin
            if (txRoll) begin
              if (txLeft_ff == 4'h0) begin
                txState_ff <= serial_port_pkg::TX_IDLE;
                txLine_ff <= 1'b1;
              end else begin
                txLine_ff <= txShift_ff[0];
                txShift_ff <= {1'b1, txShift_ff[9:1]};
                txLeft_ff <= txLeft_ff - 4'h1;
                if (txLeft_ff == 4'h1) begin
                  txStopPulse_ff <= 1'b1;
                end
              end
            end
          end
          default: begin
            txState_ff <= serial_port_pkg::TX_IDLE;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Asynchronous receiver
  // ************************************************************

  serial_port_pkg::rx_state_t rxState_ff;
  logic rxPrev_ff;
  logic [3:0] rxDiv_ff;
  logic [3:0] rxIdx_ff;
  logic [1:0] vote_ff;
  logic [8:0] rxShift_ff;
  logic rxBit;
  logic rxFall;
  logic [3:0] rxStopIdx;
  logic rxNinthVal;
  logic [7:0] rxDataVal;

  assign rxFall = sampleTick && rxPrev_ff && !rxSync;
  assign rxBit = serial_port_pkg::majority3({vote_ff, rxSync});
  assign rxStopIdx = isNine ? serial_port_pkg::RX_STOP_9 : serial_port_pkg::RX_STOP_8;
  // In mode 1 the stop bit stands in for the ninth bit.
  assign rxNinthVal = isNine ? rxShift_ff[8] : rxBit;
  assign rxDataVal = isNine ? rxShift_ff[7:0] : rxShift_ff[8:1];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxPrev_ff <= 1'b1;
    end else if (sampleTick) begin
      rxPrev_ff <= rxSync;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxState_ff <= serial_port_pkg::RX_HUNT;
      rxDiv_ff <= 4'h0;
      rxIdx_ff <= 4'h0;
      vote_ff <= 2'h0;
      rxShift_ff <= '0;
      rxAccept_ff <= 1'b0;
      rxByte_ff <= serial_port_pkg::BYTE_RESET;
      rxNinth_ff <= 1'b0;
    end else begin
      rxAccept_ff <= 1'b0;
      if (isShift) begin
        rxState_ff <= serial_port_pkg::RX_HUNT;
      end else begin
        case (rxState_ff)
          serial_port_pkg::RX_HUNT: begin
            if (rxFall && serialControl.receiveEnable && !riFlag_ff) begin
              rxState_ff <= serial_port_pkg::RX_FRAME;
              rxDiv_ff <= 4'h0;
              rxIdx_ff <= 4'h0;
            end
          end
          serial_port_pkg::RX_FRAME: begin
            if (sampleTick) begin
              rxDiv_ff <= rxDiv_ff + 4'h1;
              if (rxDiv_ff == serial_port_pkg::VOTE_FIRST) begin
                vote_ff[1] <= rxSync;
              end else if (rxDiv_ff == serial_port_pkg::VOTE_MID) begin
                vote_ff[0] <= rxSync;
              end else if (rxDiv_ff == serial_port_pkg::VOTE_LAST) begin
                rxIdx_ff <= rxIdx_ff + 4'h1;
                if (rxIdx_ff == 4'h0) begin
                  if (rxBit) begin
                    rxState_ff <= serial_port_pkg::RX_HUNT;
                  end
                end else if (rxIdx_ff == rxStopIdx) begin
                  rxState_ff <= serial_port_pkg::RX_HUNT;
                  // Frame is dropped unless the flag is clear and the ninth/stop check passes.
                  if (!riFlag_ff && (!serialControl.multiprocSpeedBit || rxNinthVal)) begin
                    rxAccept_ff <= 1'b1;
                    rxByte_ff <= rxDataVal;
                    rxNinth_ff <= rxNinthVal;
                  end
                end else begin
                  rxShift_ff <= {rxBit, rxShift_ff[8:1]};
                end
              end
            end
          end
          default: begin
            rxState_ff <= serial_port_pkg::RX_HUNT;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Pin drivers
  // ************************************************************

  // Every pin is registered once more, so all pins lag their engines by one cycle.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txdOut <= 1'b1;
      rxdOut <= 1'b1;
      rxdOe <= 1'b0;
    end else begin
      txdOut <= isShift ? m0Clk_ff : txLine_ff;
      rxdOut <= m0Data_ff;
      // Drive stays on through the last rising clock edge so the far side can latch bit 7.
      rxdOe <= isShift && ((m0State_ff == serial_port_pkg::M0_SEND) || m0TxDone_ff);
    end
  end

endmodule

/* common/serial_port_pkg.sv */
// Summary of operation
// - Two mode bits pick shift, 10-bit async, 11-bit fixed-rate or 11-bit timer-rate mode.
// - Writing the serial buffer starts a transmission in every mode.
// - Mode 0 receive starts when enabled with receive flag clear; device clocks 8 bits.
// - Async receive starts on a start bit only while enabled and receive flag clear.
// - Mode 0 data uses RxD both ways; TxD always carries the shift clock.
// - Mode 0 frame is 8 bits, LSB first, no start or stop bit.
// - Mode 0 rate is clock/12, or clock/4 when the speed bit is set.
// - Mode 0 send starts next clock; shifts right on falling shift clock, zero fill.
// - After 8 bits sent, send ends and transmit flag sets next clock.
// - Mode 0 receive starts next clock; RxD shifted left on rising shift clock.
// - After 8 bits received, receive flag sets next clock; no reception until cleared.
// - Mode 1 frame: start 0, 8 data LSB first, stop 1; stop bit kept.
// - Mode 1 bit rate is timer overflow rate divided by 16.
// - Baud timer is a 15-bit up counter pacing the divide-by-16 counter.
// - Mode 1 send begins after the next divide-by-16 rollover following the write.
// - Send start, data, stop; transmit flag sets as the stop bit begins.
// - RxD sampled at 16x; falling edge resets the divide-by-16 counter.
// - Each bit is the majority of samples at states 7, 8 and 9.
// - A start bit not read as 0 aborts and hunting resumes.
// - Mode 1 frame loads buffer and ninth bit, sets flag, only if flag was clear.
// - Mode 1 frame accepted only if speed bit is 0 or stop bit is 1.
// - Mode 2 adds a ninth bit from the control bit; received ninth bit kept.
// - Mode 2 rate is clock/64, or clock/32 with the double bit set.
// - Mode 3 uses mode 2 frames at the mode 1 timer rate.
package serial_port_pkg;

  typedef enum logic [1:0] {MODE_SHIFT, MODE_ASYNC8, MODE_ASYNC9_FIXED, MODE_ASYNC9_TIMER} mode_t;
  typedef enum logic [1:0] {M0_IDLE, M0_SEND, M0_RECV} m0_state_t;
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT} tx_state_t;
  typedef enum logic {RX_HUNT, RX_FRAME} rx_state_t;

  typedef struct packed {
    logic modeSelectHigh;
    logic modeSelectLow;
    logic multiprocSpeedBit;
    logic receiveEnable;
    logic transmitNinthBit;
  } ctrl_t;

  typedef struct packed {
    logic receiveDoneFlag;
    logic transmitDoneFlag;
    logic receivedNinthBit;
  } status_t;

  localparam logic [2:0] M0_HALF_SLOW = 3'h6;
  localparam logic [2:0] M0_HALF_FAST = 3'h2;
  localparam logic [2:0] M2_PRE_SLOW = 3'h4;
  localparam logic [2:0] M2_PRE_FAST = 3'h2;
  localparam logic [3:0] DIV16_LAST = 4'hF;
  localparam logic [3:0] VOTE_FIRST = 4'h6;
  localparam logic [3:0] VOTE_MID = 4'h7;
  localparam logic [3:0] VOTE_LAST = 4'h8;
  localparam logic [3:0] TX_LEFT_8 = 4'h9;
  localparam logic [3:0] TX_LEFT_9 = 4'hA;
  localparam logic [3:0] RX_STOP_8 = 4'h9;
  localparam logic [3:0] RX_STOP_9 = 4'hA;
  localparam logic [2:0] M0_LAST_BIT = 3'h7;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  function automatic logic majority3(input logic [2:0] s);
    majority3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
  endfunction

  function automatic logic [7:0] reverse8(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      reverse8[i] = b[7-i];
    end
  endfunction

  function automatic mode_t mode_of(input ctrl_t c);
    mode_of = mode_t'({c.modeSelectHigh, c.modeSelectLow});
  endfunction

endpackage

/* logic/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1 // Number of pins synchronised.
) (
  input wire logic clk_sys, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic [WIDTH-1:0] pinIn, // Raw pin levels.
  output logic [WIDTH-1:0] pinSync // Levels after two flip-flops.
);

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync needs at least one pin");
  end

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  // Idle serial lines sit high, so reset to ones avoids a false falling edge.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage1_ff <= '1;
      stage2_ff <= '1;
    end else begin
      stage1_ff <= pinIn;
      stage2_ff <= stage1_ff;
    end
  end

  assign pinSync = stage2_ff;

endmodule

/* logic/baud_gen.sv */
`timescale 1ns/1ps
module baud_gen #(
  parameter int RELOAD_WIDTH = 15 // Width of the baud timer.
) (
  input wire logic clk_sys, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire serial_port_pkg::mode_t mode, // Current serial mode.
  input wire logic speedBit, // Mode 0 fast shift select.
  input wire logic baudDouble, // Mode 2 double rate select.
  input wire logic [RELOAD_WIDTH-1:0] reload, // Timer reload after overflow.
  output logic sampleTick, // One pulse per sixteenth of an async bit.
  output logic shiftPhase // One pulse per half mode 0 bit.
);

  if (RELOAD_WIDTH < 2) begin : g_bad_width
    $error("baud_gen timer must be at least two bits");
  end

  logic [RELOAD_WIDTH-1:0] timer_ff;
  logic [2:0] pre_ff;
  logic [2:0] preLimit;
  logic timerOvf;
  logic preHit;

  assign timerOvf = &timer_ff;
  assign preHit = (pre_ff == preLimit - 3'h1);

  always_comb begin
    if (mode == serial_port_pkg::MODE_SHIFT) begin
      preLimit = speedBit ? serial_port_pkg::M0_HALF_FAST : serial_port_pkg::M0_HALF_SLOW;
    end else begin
      preLimit = baudDouble ? serial_port_pkg::M2_PRE_FAST : serial_port_pkg::M2_PRE_SLOW;
    end
  end

  // Up-counting timer; overflow reloads and paces the bit counters.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_ff <= '0;
    end else if (timerOvf) begin
      timer_ff <= reload;
    end else begin
      timer_ff <= timer_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= 3'h0;
    end else if (preHit) begin
      pre_ff <= 3'h0;
    end else begin
      pre_ff <= pre_ff + 3'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sampleTick <= 1'b0;
      shiftPhase <= 1'b0;
    end else begin
      shiftPhase <= preHit && (mode == serial_port_pkg::MODE_SHIFT);
      if (mode == serial_port_pkg::MODE_ASYNC9_FIXED) begin
        sampleTick <= preHit;
      end else begin
        sampleTick <= timerOvf && (mode != serial_port_pkg::MODE_SHIFT);
      end
    end
  end

endmodule

/* dv/enhanced_serial_port_chk.sv */
`timescale 1ns/1ps
module enhanced_serial_port_chk (
  input wire logic clk_sys, // System clock.
  input wire logic rst_n, // Reset, active low.
  input wire serial_port_pkg::ctrl_t serialControl, // Control bits.
  input wire logic txFlagClear, // Transmit flag clear.
  input wire logic rxFlagClear, // Receive flag clear.
  input wire logic rxdOe, // RxD drive enable.
  input wire logic txdOut, // TxD pin.
  input wire logic [7:0] serialBuffer, // Received byte.
  input wire serial_port_pkg::status_t serialStatus // Flags.
);
  // ****************************************
  // Properties
  // ****************************************
  logic [1:0] modeNow;
  logic spd;
  assign modeNow = {serialControl.modeSelectHigh, serialControl.modeSelectLow};
  assign spd = serialControl.multiprocSpeedBit;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  a_oe_shift_only: assert property (rxdOe |-> modeNow == 2'h0)
    else $error("RxD driven outside shift mode");
  a_fast_half_bit: assert property (modeNow == 2'h0 && spd && $fell(txdOut) |-> ##1 !txdOut ##1 txdOut)
    else $error("fast shift clock low phase wrong");
  a_slow_half_bit: assert property (modeNow == 2'h0 && !spd && $fell(txdOut) |-> !txdOut[*6] ##1 txdOut)
    else $error("slow shift clock low phase wrong");
  a_rx_flag_kept: assert property ($fell(serialStatus.receiveDoneFlag) |-> $past(rxFlagClear) || $past(rxFlagClear, 2))
    else $error("receive flag dropped without clear");
  a_tx_flag_kept: assert property ($fell(serialStatus.transmitDoneFlag) |-> $past(txFlagClear) || $past(txFlagClear, 2))
    else $error("transmit flag dropped without clear");
  a_buf_with_flag: assert property (!$stable(serialBuffer) |-> $rose(serialStatus.receiveDoneFlag))
    else $error("buffer loaded without receive flag");
  a_ninth_with_flag: assert property (!$stable(serialStatus.receivedNinthBit) |-> $rose(serialStatus.receiveDoneFlag))
    else $error("ninth bit loaded without receive flag");
  a_stop_with_flag: assert property ($rose(serialStatus.transmitDoneFlag) && modeNow != 2'h0 |-> ##[0:1] txdOut)
    else $error("transmit flag not at stop bit");
endmodule
bind enhanced_serial_port enhanced_serial_port_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .serialControl(serialControl), .txFlagClear(txFlagClear), .rxFlagClear(rxFlagClear),
  .rxdOe(rxdOe), .txdOut(txdOut), .serialBuffer(serialBuffer), .serialStatus(serialStatus));

/* dv/serial_peer.sv */
`timescale 1ns/1ps
module serial_peer (
  input wire logic clk_sys, // System clock.
  input wire logic txdLine, // Device TxD pin.
  input wire logic dataOut, // Device RxD drive value.
  input wire logic dataOe, // Device RxD drive enable.
  output logic lineOut // Model level on RxD, pulled up when idle.
);
  // ****************************************
  // Remote serial device
  // ****************************************
  logic [7:0] shiftCap = 8'h00;
  int edgeCount = 0;
  initial lineOut = 1'b1;
  always @(posedge txdLine) begin
    if (dataOe) begin
      shiftCap <= {dataOut, shiftCap[7:1]};
      edgeCount <= edgeCount + 1;
    end
  end
  task automatic send(input logic [10:0] bits, input int n, input int len);
    for (int i = 0; i < n; i++) begin
      lineOut <= bits[i];
      repeat (len) @(posedge clk_sys);
    end
    lineOut <= 1'b1;
  endtask
  // Sampling mid-bit keeps the model blind to the one-cycle pin lag.
  task automatic recv(output logic [9:0] got, input int n, input int len);
    int w;
    got = 10'h000;
    w = 0;
    while (txdLine !== 1'b0 && w < 5000) begin
      @(posedge clk_sys);
      w++;
    end
    repeat (len / 2) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      repeat (len) @(posedge clk_sys);
      got[i] = txdLine;
    end
    if (w >= 5000) got = 'x;
  endtask
endmodule

/* dv/enhanced_serial_port_tb.sv */
`timescale 1ns/1ps
module enhanced_serial_port_tb;
  logic clk_sys, rst_n, baudDoubleBit, txWriteStb, txFlagClear, rxFlagClear;
  logic rxdIn, rxdOut, rxdOe, txdOut, peerLine;
  logic [14:0] baudReload;
  logic [7:0] txWriteData, serialBuffer;
  serial_port_pkg::ctrl_t serialControl;
  serial_port_pkg::status_t serialStatus;
  int failures = 0;
  int tests_run = 0;
  assign rxdIn = rxdOe ? rxdOut : peerLine;
  enhanced_serial_port u_enhanced_serial_port (.clk_sys(clk_sys), .rst_n(rst_n),
    .serialControl(serialControl), .baudDoubleBit(baudDoubleBit), .baudReload(baudReload),
    .txWriteData(txWriteData), .txWriteStb(txWriteStb), .txFlagClear(txFlagClear),
    .rxFlagClear(rxFlagClear), .rxdIn(rxdIn), .rxdOut(rxdOut), .rxdOe(rxdOe),
    .txdOut(txdOut), .serialBuffer(serialBuffer), .serialStatus(serialStatus));
  serial_peer u_serial_peer (.clk_sys(clk_sys), .txdLine(txdOut), .dataOut(rxdOut),
    .dataOe(rxdOe), .lineOut(peerLine));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ****************************************
  // Helpers
  // ****************************************
  task automatic give_verdict;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t bit %b want %b", $time, got, exp);
    end
  endtask
  task automatic check_word(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t word %h want %h", $time, got, exp);
    end
  endtask
  task automatic wait_flag(input logic rx);
    for (int w = 0; (rx ? serialStatus.receiveDoneFlag : serialStatus.transmitDoneFlag) !== 1'b1; w++) begin
      if (w > 6000) begin
        failures++;
        $display("BAD %0t flag never set", $time);
        give_verdict;
      end
      @(posedge clk_sys);
    end
  endtask
  task automatic set_mode(input logic [1:0] m, input logic spd, input logic ren, input logic nb);
    serialControl <= serial_port_pkg::ctrl_t'({m, spd, ren, nb});
    @(posedge clk_sys);
  endtask
  task automatic write_byte(input logic [7:0] d);
    txWriteData <= d;
    txWriteStb <= 1'b1;
    @(posedge clk_sys);
    txWriteStb <= 1'b0;
  endtask
  task automatic clear_flags;
    txFlagClear <= 1'b1;
    rxFlagClear <= 1'b1;
    @(posedge clk_sys);
    txFlagClear <= 1'b0;
    rxFlagClear <= 1'b0;
    @(posedge clk_sys);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic sc_shift;
    int e0;
    for (int s = 0; s < 2; s++) begin
      set_mode(2'h0, s[0], 1'b0, 1'b0);
      e0 = u_serial_peer.edgeCount;
      write_byte(s ? 8'h3C : 8'hA5);
      wait_flag(1'b0);
      check_word({2'h0, u_serial_peer.shiftCap}, s ? 10'h03C : 10'h0A5);
      check_word(10'(u_serial_peer.edgeCount - e0), 10'h008);
      clear_flags;
    end
    set_mode(2'h0, 1'b1, 1'b1, 1'b0);
    wait_flag(1'b1);
    check_word({2'h0, serialBuffer}, 10'h0FF);
    set_mode(2'h0, 1'b1, 1'b0, 1'b0);
    clear_flags;
  endtask
  task automatic sc_async;
    logic [9:0] got;
    logic [7:0] d;
    int len;
    logic nine;
    // The baud timer first overflows only after a full count from reset.
    repeat (32768) @(posedge clk_sys);
    for (int k = 1; k < 5; k++) begin
      len = (k == 2) ? 32 : (k == 4) ? 64 : 16;
      nine = (k != 1);
      d = 8'h96 + 8'(k);
      baudDoubleBit <= (k == 2);
      set_mode(k == 4 ? 2'h2 : 2'(k), 1'b0, 1'b1, k[0]);
      write_byte(d);
      u_serial_peer.recv(got, nine ? 10 : 9, len);
      check_word(got, nine ? {1'b1, k[0], d} : {2'h1, d});
      check_bit(serialStatus.transmitDoneFlag, 1'b1);
      u_serial_peer.send({1'b1, nine ? k[1] : 1'b1, ~d, 1'b0}, nine ? 11 : 10, len);
      wait_flag(1'b1);
      check_word({1'b0, serialStatus.receivedNinthBit, serialBuffer}, {1'b0, nine ? k[1] : 1'b1, ~d});
      clear_flags;
    end
  endtask
  task automatic sc_gating;
    set_mode(2'h1, 1'b0, 1'b1, 1'b0);
    u_serial_peer.send(11'h000, 1, 4);
    repeat (30) @(posedge clk_sys);
    u_serial_peer.send({2'h3, 8'hC3, 1'b0}, 10, 16);
    wait_flag(1'b1);
    check_word({2'h0, serialBuffer}, 10'h0C3);
    u_serial_peer.send({2'h3, 8'h11, 1'b0}, 10, 16);
    repeat (20) @(posedge clk_sys);
    check_word({2'h0, serialBuffer}, 10'h0C3);
    clear_flags;
    set_mode(2'h1, 1'b1, 1'b1, 1'b0);
    u_serial_peer.send({2'h0, 8'h77, 1'b0}, 10, 16);
    repeat (40) @(posedge clk_sys);
    check_bit(serialStatus.receiveDoneFlag, 1'b0);
    u_serial_peer.send({2'h3, 8'h77, 1'b0}, 10, 16);
    wait_flag(1'b1);
    check_word({2'h0, serialBuffer}, 10'h077);
    clear_flags;
  endtask
  initial begin
    rst_n = 1'b0;
    serialControl = '0;
    baudDoubleBit = 1'b0;
    baudReload = 15'h7FFF;
    txWriteData = 8'h00;
    txWriteStb = 1'b0;
    txFlagClear = 1'b0;
    rxFlagClear = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    check_word({rxdOe, txdOut, serialBuffer}, 10'h100);
    check_word({7'h00, serialStatus}, 10'h000);
    sc_shift;
    sc_async;
    sc_gating;
    give_verdict;
  end
endmodule
